// ### hw/stc_pkg.sv
// shared constants for the timing reference configuration block
package stc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [6:0] ADDR_PRI_BASE = 7'h10;   // 14 priority regs
  localparam logic [6:0] ADDR_FREQ_BASE = 7'h20;  // 14 frequency regs
  localparam logic [6:0] ADDR_MS_SEL = 7'h30;
  localparam logic [6:0] ADDR_OP_CFG = 7'h34;
  localparam logic [6:0] ADDR_RATE_AUX = 7'h38;
  localparam logic [6:0] ADDR_TRIM_LO = 7'h3C;
  localparam logic [6:0] ADDR_TRIM_HI = 7'h3D;
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h40;
  localparam logic [6:0] ADDR_BW_SEL = 7'h41;
  localparam logic [6:0] ADDR_STATUS = 7'h42;
  localparam logic [6:0] ADDR_DIV_LO = 7'h46;
  localparam logic [6:0] ADDR_DIV_HI = 7'h47;
  localparam int NUM_INPUTS = 14;
  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int OP_NET_BIT = 2;
  localparam int AUX_RATE_BIT0 = 5;
  localparam int AUX_RATE_BIT1 = 6;
  localparam int FREQ_LOCK8K_BIT = 6;
  localparam int FREQ_DIVN_BIT = 7;
  localparam logic [15:0] TRIM_RESET = 16'h9999;
  localparam logic [7:0] OP_CFG_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [13:0] DIV_RESET = 14'h0000;
  localparam logic [2:0] BW_RESET = 3'h0;
  localparam logic [2:0] BW_MAX = 3'h7;       // 0.1 Hz .. 20 Hz points
  localparam logic [3:0] PRI_SLAVE_I11 = 4'h1;
  localparam logic [3:0] PRI_NONE = 4'h0;      // priority 0 = disabled
  localparam logic [3:0] NO_REF = 4'hF;
  // spot frequency codes, low nibble of a frequency register
  localparam logic [3:0] FQ_8K = 4'h0;
  localparam logic [3:0] FQ_DIG = 4'h1;        // 1.544 or 2.048 MHz
  localparam logic [3:0] FQ_6M48 = 4'h2;
  localparam logic [3:0] FQ_19M44 = 4'h3;
  localparam logic [3:0] FQ_25M92 = 4'h4;
  localparam logic [3:0] FQ_38M88 = 4'h5;
  localparam logic [3:0] FQ_51M84 = 4'h6;
  localparam logic [3:0] FQ_77M76 = 4'h7;
  localparam logic [3:0] FQ_2K = 4'h8;
  localparam logic [3:0] FQ_4K = 4'h9;
  localparam logic [3:0] FQ_CC64 = 4'hA;       // composite 64/8 kHz
  localparam logic [3:0] FQ_MAX = 4'hA;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int FS_HALF_NS = 62500;           // half of 8 kHz
  localparam int FS_HALF_CYC = FS_HALF_NS / CLK_PERIOD_NS;
  localparam logic [11:0] FS_LAST = 12'(FS_HALF_CYC - 1);
  localparam logic [1:0] MFS_LAST = 2'h3;      // 4 halves of 8k per half
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_FREE = 2'b00,
    ST_LOCKED = 2'b01,
    ST_HOLD = 2'b11
  } stc_mode_t;
  typedef enum logic [1:0] {
    SRC_OSC = 2'h0,
    SRC_REF = 2'h1,
    SRC_HOLD = 2'h2
  } stc_src_t;
  localparam logic [1:0] FORCE_AUTO = 2'h0;
  localparam logic [1:0] FORCE_FREE = 2'h1;
  localparam logic [1:0] FORCE_HOLD = 2'h2;
endpackage

// ### hw/stc_timing_cfg.sv
// timing reference configuration, mode control and sync generation
// Summary of operation
// - rate-family bits 0x34.2, 0x38.5/6 load from rate pin after reset
// - bit 2 of 0x34 selects SONET when one, SDH when zero
// - free-run takes output timing from the local oscillator only
// - locked picks best valid reference and locks to it
// - holdover uses oscillator corrected to last reference's frequency
// - loop bandwidth selectable over eight points, 0.1 Hz to 20 Hz
// - paired devices share only sync phase; a slave aligns to the partner's 2 kHz
// - master timing comes from the 12.80 MHz oscillator clock
// - trim is 16 bits from two byte registers, 0.02 ppm per step
// - trim resets to 39321, full range 0 to 65535
// - fourteen reference inputs, each of one of three source types
// - every input gets default frequency and priority at reset
// - any input may serve any source type within its speed
// - single-ended spot frequencies 2k, 4k, 8k, dig, 6.48..77.76 MHz
// - each input's expected frequency comes from its frequency register
// - optional pre-divider ahead of the phase comparator, enabled only when freq bits 6 and 7 are both set
// - 8 kHz frame sync and 2 kHz multi-frame sync outputs
// - master/slave register loads from its pin after reset
`timescale 1ns/1ps
module stc_timing_cfg
  import stc_pkg::*;
(
  // clock and reset, CLK is the 12.80 MHz-derived system clock
  input wire logic CLK,
  input wire logic RESET_N,
  // strap pins
  input wire logic RATE_FAMILY_SELECT_PIN,
  input wire logic PRIMARY_SECONDARY_SELECT_PIN,
  // microprocessor port
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [6:0] ADDR,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic RDY,
  // reference monitor results and partner sync
  input wire logic [13:0] REF_VALID,
  input wire logic SYNC_2K_IN,
  // timing engine controls
  output stc_pkg::stc_mode_t MODE,
  output stc_pkg::stc_src_t NCO_SOURCE,
  output logic [3:0] SELECTED_REF,
  output logic [3:0] SELECTED_FREQ,
  output logic PREDIV_EN,
  output logic [13:0] PREDIV_RATIO,
  output logic [15:0] TRIM_VALUE,
  output logic [2:0] BW_SEL,
  output logic SONET_SELECT,
  output logic MASTER_SELECT,
  // sync outputs
  output logic FRAME_SYNC,
  output logic MFRAME_SYNC
);
  import stc_pkg::*;

  // ****************************************************************
  // strap load and bus front end
  // ****************************************************************
  logic load_pend_reg;
  logic wr_n_q_reg;
  logic rd_n_q_reg;
  logic [7:0] op_cfg_reg;
  logic [7:0] aux_reg;
  logic [15:0] trim_reg;
  logic ms_reg;
  logic [1:0] force_reg;
  logic [2:0] bw_reg;
  logic [13:0] div_reg;
  logic [3:0] pri_reg [NUM_INPUTS];
  logic [7:0] freq_reg [NUM_INPUTS];
  logic [3:0] sel_reg;
  logic ever_locked_reg;
  stc_mode_t mode_reg;
  stc_mode_t mode_next;

  // write takes effect on the falling edge of the write strobe
  wire wr_stb = !CS_N && !WR_N && wr_n_q_reg;
  wire rd_act = !CS_N && !RD_N;
  wire [6:0] pri_off = ADDR - ADDR_PRI_BASE;
  wire [6:0] freq_off = ADDR - ADDR_FREQ_BASE;
  wire pri_hit = (ADDR >= ADDR_PRI_BASE) && (pri_off < 7'(NUM_INPUTS));
  wire freq_hit = (ADDR >= ADDR_FREQ_BASE) && (freq_off < 7'(NUM_INPUTS));
  wire wr_op = wr_stb && (ADDR == ADDR_OP_CFG);
  wire wr_aux = wr_stb && (ADDR == ADDR_RATE_AUX);
  wire wr_tlo = wr_stb && (ADDR == ADDR_TRIM_LO);
  wire wr_thi = wr_stb && (ADDR == ADDR_TRIM_HI);
  wire wr_ms = wr_stb && (ADDR == ADDR_MS_SEL);
  wire wr_mode = wr_stb && (ADDR == ADDR_MODE_CTRL);
  wire wr_bw = wr_stb && (ADDR == ADDR_BW_SEL);
  wire wr_dlo = wr_stb && (ADDR == ADDR_DIV_LO);
  wire wr_dhi = wr_stb && (ADDR == ADDR_DIV_HI);

  // strobe history and strap load flag, load happens once after release
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      load_pend_reg <= 1'b1;
      wr_n_q_reg <= 1'b1;
      rd_n_q_reg <= 1'b1;
    end else begin
      load_pend_reg <= 1'b0;
      wr_n_q_reg <= WR_N;
      rd_n_q_reg <= RD_N;
    end
  end

  // ****************************************************************
  // global configuration registers
  // ****************************************************************
  // strap load wins over a bus write landing in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      op_cfg_reg <= OP_CFG_RESET;
      aux_reg <= AUX_RESET;
      ms_reg <= 1'b1;
    end else if (load_pend_reg) begin
      op_cfg_reg[OP_NET_BIT] <= RATE_FAMILY_SELECT_PIN;
      aux_reg[AUX_RATE_BIT0] <= RATE_FAMILY_SELECT_PIN;
      aux_reg[AUX_RATE_BIT1] <= RATE_FAMILY_SELECT_PIN;
      ms_reg <= PRIMARY_SECONDARY_SELECT_PIN;
    end else begin
      if (wr_op) op_cfg_reg <= DATA_IN;
      if (wr_aux) aux_reg <= DATA_IN;
      if (wr_ms) ms_reg <= DATA_IN[0];
    end
  end

  // trim, bandwidth, forced mode and pre-divider ratio
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trim_reg <= TRIM_RESET;
      bw_reg <= BW_RESET;
      force_reg <= FORCE_AUTO;
      div_reg <= DIV_RESET;
    end else begin
      if (wr_tlo) trim_reg[7:0] <= DATA_IN;
      if (wr_thi) trim_reg[15:8] <= DATA_IN;
      if (wr_bw && DATA_IN[2:0] <= BW_MAX) bw_reg <= DATA_IN[2:0];
      if (wr_mode) force_reg <= DATA_IN[1:0];
      if (wr_dlo) div_reg[7:0] <= DATA_IN;
      if (wr_dhi) div_reg[13:8] <= DATA_IN[5:0];
    end
  end

  // ****************************************************************
  // per-input priority and frequency, plus best-reference search
  // ****************************************************************
  logic [3:0] best_pri [NUM_INPUTS+1];
  logic [3:0] best_idx [NUM_INPUTS+1];
  assign best_pri[0] = PRI_NONE;
  assign best_idx[0] = NO_REF;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
      // table defaults: priority port+1, slave moves input 11 to one
      localparam logic [3:0] DEF_PRI = 4'(gi + 2);
      localparam logic [3:0] DEF_FQ = (gi < 2) ? FQ_CC64 :
                                      (gi < 4) ? FQ_8K :
                                      (gi < 10) ? FQ_19M44 : FQ_DIG;
      wire wr_pri = wr_stb && pri_hit && (pri_off == 7'(gi));
      wire wr_fq = wr_stb && freq_hit && (freq_off == 7'(gi));
      wire usable = REF_VALID[gi] && (pri_reg[gi] != PRI_NONE);
      wire better = usable && ((best_pri[gi] == PRI_NONE) ||
                               (pri_reg[gi] < best_pri[gi]));
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          pri_reg[gi] <= DEF_PRI;
          freq_reg[gi] <= {4'h0, DEF_FQ};
        end else if (load_pend_reg) begin
          if (gi == 10 && !PRIMARY_SECONDARY_SELECT_PIN) begin
            pri_reg[gi] <= PRI_SLAVE_I11;
            freq_reg[gi] <= {4'h0, FQ_6M48};
          end
        end else begin
          if (wr_pri) pri_reg[gi] <= DATA_IN[3:0];
          // codes past the spot list are refused, any port any type
          if (wr_fq && DATA_IN[3:0] <= FQ_MAX) begin
            freq_reg[gi] <= DATA_IN;
          end
        end
      end
      // lowest non-zero priority wins, ties go to the lower port
      assign best_pri[gi+1] = better ? pri_reg[gi] : best_pri[gi];
      assign best_idx[gi+1] = better ? 4'(gi) : best_idx[gi];
    end
  endgenerate

  wire best_found = best_idx[NUM_INPUTS] != NO_REF;
  wire [3:0] best_ref = best_idx[NUM_INPUTS];

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  // automatic mode follows reference availability; forcing overrides
  always_comb begin
    mode_next = mode_reg;
    case (force_reg)
      FORCE_FREE: mode_next = ST_FREE;
      FORCE_HOLD: mode_next = ever_locked_reg ? ST_HOLD : ST_FREE;
      default: begin
        if (best_found) mode_next = ST_LOCKED;
        else if (ever_locked_reg) mode_next = ST_HOLD;
        else mode_next = ST_FREE;
      end
    endcase
  end

  // holdover keeps the last selection so its frequency memory applies
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_reg <= ST_FREE;
      sel_reg <= NO_REF;
      ever_locked_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (mode_next == ST_LOCKED) sel_reg <= best_ref;
      if (mode_next == ST_LOCKED) ever_locked_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // frame and multi-frame sync generation
  // ****************************************************************
  logic [11:0] fs_cnt_reg;
  logic [1:0] mfs_cnt_reg;
  logic sync_s1_reg;
  logic sync_s2_reg;
  logic sync_s3_reg;
  // a slave realigns its 2 kHz phase to the partner's rising edge
  wire align = !ms_reg && sync_s2_reg && !sync_s3_reg;
  wire fs_wrap = fs_cnt_reg == FS_LAST;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
    end else begin
      sync_s1_reg <= SYNC_2K_IN;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  // counters on the oscillator clock keep sync alive in every mode
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fs_cnt_reg <= 12'h000;
      mfs_cnt_reg <= 2'h0;
      FRAME_SYNC <= 1'b0;
      MFRAME_SYNC <= 1'b0;
    end else if (align) begin
      fs_cnt_reg <= 12'h000;
      mfs_cnt_reg <= 2'h0;
      FRAME_SYNC <= 1'b1;
      MFRAME_SYNC <= 1'b1;
    end else if (fs_wrap) begin
      fs_cnt_reg <= 12'h000;
      FRAME_SYNC <= !FRAME_SYNC;
      mfs_cnt_reg <= mfs_cnt_reg + 2'h1;
      if (mfs_cnt_reg == MFS_LAST) MFRAME_SYNC <= !MFRAME_SYNC;
    end else begin
      fs_cnt_reg <= fs_cnt_reg + 12'h001;
    end
  end

  // ****************************************************************
  // read path and outputs
  // ****************************************************************
  wire [7:0] status_byte = {2'h0, mode_reg, sel_reg};
  wire [7:0] rd_pri = pri_hit ? {4'h0, pri_reg[pri_off[3:0]]} : 8'h00;
  wire [7:0] rd_fq = freq_hit ? freq_reg[freq_off[3:0]] : 8'h00;
  wire [7:0] rd_mux =
    (ADDR == ADDR_OP_CFG) ? op_cfg_reg :
    (ADDR == ADDR_RATE_AUX) ? aux_reg :
    (ADDR == ADDR_TRIM_LO) ? trim_reg[7:0] :
    (ADDR == ADDR_TRIM_HI) ? trim_reg[15:8] :
    (ADDR == ADDR_MS_SEL) ? {7'h00, ms_reg} :
    (ADDR == ADDR_MODE_CTRL) ? {6'h00, force_reg} :
    (ADDR == ADDR_BW_SEL) ? {5'h00, bw_reg} :
    (ADDR == ADDR_STATUS) ? status_byte :
    (ADDR == ADDR_DIV_LO) ? div_reg[7:0] :
    (ADDR == ADDR_DIV_HI) ? {2'h0, div_reg[13:8]} :
    (rd_pri | rd_fq); // unmapped reads as zero
  wire [3:0] cur_ref = (mode_reg == ST_FREE) ? NO_REF : sel_reg;
  wire [7:0] cur_fq = (cur_ref == NO_REF) ? 8'h00 : freq_reg[cur_ref];
  wire [1:0] src_next = (mode_reg == ST_LOCKED) ? SRC_REF :
                        (mode_reg == ST_HOLD) ? SRC_HOLD : SRC_OSC;

  // bus answer: data and ready one cycle after the strobe is seen
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_OUT <= 8'h00;
      DATA_OE_N <= 1'b1;
      RDY <= 1'b0;
    end else begin
      if (rd_act) DATA_OUT <= rd_mux;
      DATA_OE_N <= !rd_act;
      RDY <= !CS_N && (!RD_N || !WR_N);
    end
  end

  // engine controls, all registered
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MODE <= ST_FREE;
      NCO_SOURCE <= SRC_OSC;
      SELECTED_REF <= NO_REF;
      SELECTED_FREQ <= FQ_8K;
      PREDIV_EN <= 1'b0;
      PREDIV_RATIO <= DIV_RESET;
      TRIM_VALUE <= TRIM_RESET;
      BW_SEL <= BW_RESET;
      SONET_SELECT <= 1'b0;
      MASTER_SELECT <= 1'b1;
    end else begin
      MODE <= mode_reg;
      NCO_SOURCE <= stc_src_t'(src_next);
      SELECTED_REF <= cur_ref;
      SELECTED_FREQ <= cur_fq[3:0];
      PREDIV_EN <= cur_fq[FREQ_DIVN_BIT] && cur_fq[FREQ_LOCK8K_BIT];
      PREDIV_RATIO <= div_reg;
      TRIM_VALUE <= trim_reg;
      BW_SEL <= bw_reg;
      SONET_SELECT <= op_cfg_reg[OP_NET_BIT];
      MASTER_SELECT <= ms_reg;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_RATE_LOAD: assert property (
    load_pend_reg |=> op_cfg_reg[OP_NET_BIT] == $past(RATE_FAMILY_SELECT_PIN)
      && aux_reg[AUX_RATE_BIT1] == $past(RATE_FAMILY_SELECT_PIN))
    else $error("rate family not loaded from pin");
  AST_NET_OUT: assert property (
    wr_op && !load_pend_reg |=> ##1 SONET_SELECT == $past(DATA_IN[2], 2))
    else $error("network type output wrong");
  AST_FREE_SRC: assert property (
    mode_reg == ST_FREE |=> NCO_SOURCE == SRC_OSC)
    else $error("free-run not on oscillator");
  // judged on the edge that chose the reference, a later loss is holdover
  AST_LOCK_VALID: assert property (
    mode_reg == ST_LOCKED |-> $past(best_found) && $past(REF_VALID[best_ref]))
    else $error("locked to an invalid reference");
  AST_HOLD_KEEP: assert property (
    mode_reg == ST_HOLD |-> $stable(sel_reg))
    else $error("holdover changed reference");
  AST_TRIM_WR: assert property (
    wr_thi && !load_pend_reg |=> trim_reg[15:8] == $past(DATA_IN) ##1
      TRIM_VALUE[15:8] == $past(DATA_IN, 2))
    else $error("trim high byte not applied");
  // helper: age of the current frame sync level, a realign voids one half
  logic fs_seen_reg;
  logic fs_clean_reg;
  logic [11:0] fs_age_reg;
  wire fs_moved = FRAME_SYNC != fs_seen_reg;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fs_seen_reg <= 1'b0;
      fs_clean_reg <= 1'b1;
      fs_age_reg <= 12'h000;
    end else begin
      fs_seen_reg <= FRAME_SYNC;
      fs_age_reg <= fs_moved ? 12'h001 : fs_age_reg + 12'h001;
      if (align) fs_clean_reg <= 1'b0;
      else if (fs_moved) fs_clean_reg <= 1'b1;
    end
  end
  AST_FS_HALF: assert property (
    fs_moved && fs_clean_reg |-> fs_age_reg == 12'(FS_HALF_CYC))
    else $error("frame sync half period wrong");
  AST_MS_LOAD: assert property (
    load_pend_reg |=> ms_reg == $past(PRIMARY_SECONDARY_SELECT_PIN))
    else $error("master select not loaded from pin");
  AST_HOLD_ENTRY: assert property (
    force_reg == FORCE_AUTO && !best_found |=> mode_reg ==
      ($past(ever_locked_reg) ? ST_HOLD : ST_FREE))
    else $error("wrong fallback mode");
  AST_ALIGN: assert property (
    align |=> FRAME_SYNC && MFRAME_SYNC && fs_cnt_reg == 12'h000)
    else $error("slave sync not realigned");

  COV_LOCK: cover property (mode_reg == ST_FREE ##1 mode_reg == ST_LOCKED);
  COV_HOLD: cover property (mode_reg == ST_LOCKED ##1 mode_reg == ST_HOLD);
  COV_ALIGN: cover property (align);
  COV_RELOCK: cover property (mode_reg == ST_HOLD ##1 mode_reg == ST_LOCKED);
endmodule

// ### dv/stc_ref_model.sv
// reference monitors and partner sync source facing the block
`timescale 1ns/1ps
module stc_ref_model #(
  parameter int HALF_CYC = 10000
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // bench controls
  input wire logic [13:0] valid_req,
  input wire logic sync_en,
  // toward the block
  output logic [13:0] REF_VALID,
  output logic SYNC_2K_IN
);
  int cnt_reg;
  // monitors report one edge late; partner sync idles low (pull-down)
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REF_VALID <= 14'h0000;
      SYNC_2K_IN <= 1'b0;
      cnt_reg <= 0;
    end else begin
      REF_VALID <= valid_req;
      if (!sync_en) begin
        SYNC_2K_IN <= 1'b0;
        cnt_reg <= 0;
      end else if (cnt_reg == HALF_CYC - 1) begin
        SYNC_2K_IN <= ~SYNC_2K_IN; // partner multiframe square
        cnt_reg <= 0;
      end else begin
        cnt_reg <= cnt_reg + 1;
      end
    end
  end
endmodule

// ### dv/testbench.sv
// self-checking bench for the timing reference configuration block
`timescale 1ns/1ps
module testbench;
  import stc_pkg::*;
  logic CLK = 1'b0, RESET_N = 1'b0, RATE_FAMILY_SELECT_PIN = 1'b1;
  logic PRIMARY_SECONDARY_SELECT_PIN = 1'b1, CS_N = 1'b1, WR_N = 1'b1;
  logic RD_N = 1'b1, sync_en = 1'b0;
  logic [6:0] ADDR = 7'h00;
  logic [7:0] DATA_IN = 8'h00, DATA_OUT, q;
  logic [13:0] valid_req = 14'h0000, REF_VALID, PREDIV_RATIO;
  logic SYNC_2K_IN, DATA_OE_N, RDY, PREDIV_EN, SONET_SELECT;
  logic MASTER_SELECT, FRAME_SYNC, MFRAME_SYNC;
  stc_mode_t MODE;
  stc_src_t NCO_SOURCE;
  logic [3:0] SELECTED_REF, SELECTED_FREQ;
  logic [15:0] TRIM_VALUE;
  logic [2:0] BW_SEL;
  int fail_count = 0, cmp_count = 0;
  // ******************************************************
  // instances and clock
  // ******************************************************
  always #12.5 CLK = ~CLK;
  stc_timing_cfg i_stc_timing_cfg (.CLK(CLK), .RESET_N(RESET_N),
    .RATE_FAMILY_SELECT_PIN(RATE_FAMILY_SELECT_PIN),
    .PRIMARY_SECONDARY_SELECT_PIN(PRIMARY_SECONDARY_SELECT_PIN),
    .CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N), .ADDR(ADDR),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
    .RDY(RDY), .REF_VALID(REF_VALID), .SYNC_2K_IN(SYNC_2K_IN),
    .MODE(MODE), .NCO_SOURCE(NCO_SOURCE), .SELECTED_REF(SELECTED_REF),
    .SELECTED_FREQ(SELECTED_FREQ), .PREDIV_EN(PREDIV_EN),
    .PREDIV_RATIO(PREDIV_RATIO), .TRIM_VALUE(TRIM_VALUE),
    .BW_SEL(BW_SEL), .SONET_SELECT(SONET_SELECT),
    .MASTER_SELECT(MASTER_SELECT), .FRAME_SYNC(FRAME_SYNC),
    .MFRAME_SYNC(MFRAME_SYNC));
  // short partner half period keeps the slave test brief
  stc_ref_model #(.HALF_CYC(200)) i_stc_ref_model (.CLK(CLK),
    .RESET_N(RESET_N), .valid_req(valid_req), .sync_en(sync_en),
    .REF_VALID(REF_VALID), .SYNC_2K_IN(SYNC_2K_IN));
  // ******************************************************
  // shared tasks
  // ******************************************************
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic timeout(input string what);
    fail_count++;
    $display("mismatch at %0t: timeout on %s", $time, what);
    close_out();
  endtask
  // strobes held until RDY is sampled high, then one idle edge
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    CS_N <= 1'b0;
    WR_N <= !wr;
    RD_N <= wr;
    ADDR <= a;
    DATA_IN <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (RDY !== 1'b1 && n < 20);
    if (n >= 20) timeout("bus");
    q = DATA_OUT;
    if (!wr) check(DATA_OE_N, 1'b0, "oe");
    CS_N <= 1'b1;
    WR_N <= 1'b1;
    RD_N <= 1'b1;
    @(posedge CLK);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(q, e, "read");
  endtask
  task automatic do_reset(input logic rate, input logic ms);
    RESET_N <= 1'b0;
    RATE_FAMILY_SELECT_PIN <= rate;
    PRIMARY_SECONDARY_SELECT_PIN <= ms;
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
  endtask
  // ******************************************************
  // scenarios
  // ******************************************************
  task automatic t_straps();
    do_reset(1'b0, 1'b1);
    check(SONET_SELECT, 1'b0, "sdh strap");
    rd_chk(ADDR_OP_CFG, 8'h00);
    rd_chk(ADDR_FREQ_BASE + 7'd12, {4'h0, FQ_DIG});
    do_reset(1'b1, 1'b0);
    check(MASTER_SELECT, 1'b0, "slave strap");
    rd_chk(ADDR_PRI_BASE + 7'd10, 8'h01);
    rd_chk(ADDR_FREQ_BASE + 7'd10, {4'h0, FQ_6M48});
    do_reset(1'b1, 1'b1);
    check(SONET_SELECT, 1'b1, "sonet strap");
    check(MASTER_SELECT, 1'b1, "master strap");
    rd_chk(ADDR_OP_CFG, 8'h04);
    rd_chk(ADDR_RATE_AUX, 8'h60);
    rd_chk(ADDR_PRI_BASE + 7'd10, 8'h0C);
    bus(1'b1, ADDR_OP_CFG, 8'h00);
    repeat (2) @(posedge CLK);
    check(SONET_SELECT, 1'b0, "sw network type");
    $display("test straps done");
  endtask
  task automatic t_trim();
    check(TRIM_VALUE, 16'd39321, "trim reset");
    bus(1'b1, ADDR_TRIM_LO, 8'hFF);
    bus(1'b1, ADDR_TRIM_HI, 8'hFF);
    check(TRIM_VALUE, 16'd65535, "trim max");
    bus(1'b1, ADDR_TRIM_LO, 8'h9F);
    bus(1'b1, ADDR_TRIM_HI, 8'h98);
    check(TRIM_VALUE, 16'd39071, "trim -5ppm");
    $display("test trim done");
  endtask
  task automatic t_modes();
    check(MODE, ST_FREE, "free mode");
    check(NCO_SOURCE, SRC_OSC, "free source");
    check(SELECTED_REF, NO_REF, "no ref");
    valid_req <= 14'h0010;
    repeat (4) @(posedge CLK);
    check(MODE, ST_LOCKED, "lock");
    check(NCO_SOURCE, SRC_REF, "ref source");
    check(SELECTED_REF, 4'h4, "ref 5");
    check(SELECTED_FREQ, FQ_19M44, "ref 5 freq");
    rd_chk(ADDR_STATUS, 8'h14);
    valid_req <= 14'h0014;
    repeat (4) @(posedge CLK);
    check(SELECTED_REF, 4'h2, "better priority");
    check(SELECTED_FREQ, FQ_8K, "ref 3 freq");
    valid_req <= 14'h0000;
    repeat (4) @(posedge CLK);
    check(MODE, ST_HOLD, "holdover");
    check(NCO_SOURCE, SRC_HOLD, "hold source");
    check(SELECTED_REF, 4'h2, "hold keeps ref");
    bus(1'b1, ADDR_MODE_CTRL, {6'h00, FORCE_FREE});
    repeat (2) @(posedge CLK);
    check(MODE, ST_FREE, "forced free");
    check(SELECTED_REF, NO_REF, "forced free ref");
    bus(1'b1, ADDR_MODE_CTRL, {6'h00, FORCE_HOLD});
    repeat (2) @(posedge CLK);
    check(NCO_SOURCE, SRC_HOLD, "forced hold");
    check(SELECTED_REF, 4'h2, "forced hold ref");
    bus(1'b1, ADDR_MODE_CTRL, {6'h00, FORCE_AUTO});
    $display("test modes done");
  endtask
  task automatic t_freq();
    valid_req <= 14'h0010;
    bus(1'b1, ADDR_FREQ_BASE + 7'd4, 8'hC2);
    repeat (3) @(posedge CLK);
    check(SELECTED_FREQ, FQ_6M48, "freq write");
    check(PREDIV_EN, 1'b1, "predivider on");
    bus(1'b1, ADDR_FREQ_BASE + 7'd4, 8'h0B);
    rd_chk(ADDR_FREQ_BASE + 7'd4, 8'hC2);
    bus(1'b1, ADDR_PRI_BASE + 7'd4, 8'h00);
    repeat (4) @(posedge CLK);
    check(MODE, ST_HOLD, "priority 0 disables");
    bus(1'b1, ADDR_BW_SEL, 8'h07);
    check(BW_SEL, BW_MAX, "bandwidth");
    bus(1'b1, ADDR_DIV_LO, 8'hE1);
    bus(1'b1, ADDR_DIV_HI, 8'hC4);
    check(PREDIV_RATIO, 14'h04E1, "divider ratio");
    rd_chk(ADDR_DIV_HI, 8'h04);
    rd_chk(7'h7F, 8'h00);
    $display("test freq done");
  endtask
  task automatic t_sync();
    int n, c;
    n = 0;
    c = 0;
    while (FRAME_SYNC === 1'b0 && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    while (FRAME_SYNC === 1'b1 && c < 3000) begin
      @(posedge CLK);
      c++;
    end
    if (n >= 3000 || c >= 3000) timeout("frame sync");
    check(16'(c), 16'(FS_HALF_CYC), "frame half period");
    bus(1'b1, ADDR_MS_SEL, 8'h00);
    sync_en <= 1'b1;
    n = 0;
    while (SYNC_2K_IN !== 1'b1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 400) timeout("partner sync");
    repeat (5) @(posedge CLK);
    check({FRAME_SYNC, MFRAME_SYNC}, 2'b11, "slave align");
    sync_en <= 1'b0;
    $display("test sync done");
  endtask
  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    t_straps();
    t_trim();
    t_modes();
    t_freq();
    t_sync();
    close_out();
  end
endmodule
